/* common/dac_port_regs.vh */
// Register offsets, field positions, reset values and timing counts of the DAC port controller.
`ifndef DAC_PORT_REGS_VH
`define DAC_PORT_REGS_VH
`define REG_LEVEL 4'h0
`define REG_CTRL 4'h1
`define REG_STATUS 4'h2
`define REG_ID 4'h3
`define REG_SHADOW0 4'h4
`define CTRL_GO_BIT 0
`define CTRL_CLEAR_BIT 1
`define CTRL_CH_LSB 4
`define CTRL_CH_MSB 5
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_CLR_DONE_BIT 2
`define LEVEL_RESET 12'h000
`define CLK_PERIOD_NS 10
`define SELECT_LOW_NS 50
`define RESET_LOW_NS 50
`define SELECT_LOW_CYC ((`SELECT_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_LOW_CYC ((`RESET_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Arbitrary identification value.
`define ID_VALUE 16'h5A01
`endif

/* core/pulse_timer.v */
// Low-pulse timer that holds an active-low line for a fixed number of cycles.
`timescale 1ns/1ps
module pulse_timer #(
   parameter CYCLES = 5
) (
   input wire i_ref_clk,
   input wire i_rst,
   input wire i_start,
   output wire o_active,
   output wire o_done
);
   reg [7:0] count_q;
   reg [7:0] count_d;
   always @* begin
      count_d = count_q;
      if (i_start && count_q == 8'h00) begin
         count_d = CYCLES[7:0];
      end else if (count_q != 8'h00) begin
         count_d = count_q - 8'h01;
      end
   end
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         count_q <= 8'h00;
      end else begin
         count_q <= count_d;
      end
   end
   assign o_active = (count_q != 8'h00);
   assign o_done = (count_q == 8'h01);
endmodule // pulse_timer

/* core/dac_port_host.v */
// Host controller that writes levels into a four-channel DAC card over its parallel port.
`timescale 1ns/1ps
`include "dac_port_regs.vh"
module dac_port_host #(
   parameter SELECT_CYC = `SELECT_LOW_CYC,
   parameter RESET_CYC = `RESET_LOW_CYC
) (
   input wire i_ref_clk,
   input wire i_rst,
   input wire [3:0] i_addr,
   input wire [15:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [15:0] o_rdata,
   output reg [11:0] o_level_word,
   output reg o_channel_sel_low,
   output reg o_channel_sel_high,
   output reg o_load_n,
   output reg o_board_sel_n,
   output reg o_clear_n
);
   localparam ST_IDLE = 2'h0;
   localparam ST_SETUP = 2'h1;
   localparam ST_SELECT = 2'h2;
   localparam ST_RELEASE = 2'h3;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [11:0] level_q;
   reg [1:0] chan_q;
   reg go_q;
   reg clear_req_q;
   reg clear_run_q;
   reg done_q;
   reg clr_done_q;
   reg boot_q;
   wire sel_active;
   wire sel_done;
   wire clr_active;
   wire clr_done;
   wire sel_start;
   wire clr_start;
   wire busy;
   wire wr_level;
   wire wr_ctrl;
   wire rd_status;
   wire [3:0] chan_hot;
   wire [47:0] shadow_w;
   reg [11:0] shadow_rd;
   // A pending go counts as busy, else a second go could slip in and be lost.
   assign busy = go_q || (state_q != ST_IDLE) || sel_active || clr_active || clear_run_q;
   assign wr_level = i_wr && i_addr == `REG_LEVEL;
   assign wr_ctrl = i_wr && i_addr == `REG_CTRL;
   assign rd_status = i_rd && i_addr == `REG_STATUS;
   assign chan_hot = 4'h1 << chan_q;
   assign sel_start = (state_q == ST_SETUP);
   // The clear is not overlapped with a write so a write never lands in a clearing card.
   assign clr_start = (clear_req_q || boot_q) && !clear_run_q && state_q == ST_IDLE;
   pulse_timer #(.CYCLES(SELECT_CYC)) u_sel_timer (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_start(sel_start),
      .o_active(sel_active),
      .o_done(sel_done)
   );
   pulse_timer #(.CYCLES(RESET_CYC)) u_clr_timer (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_start(clr_start),
      .o_active(clr_active),
      .o_done(clr_done)
   );
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (go_q && !clear_req_q && !boot_q && !clear_run_q) begin
               state_d = ST_SETUP;
            end
         end
         ST_SETUP: begin
            state_d = ST_SELECT;
         end
         ST_SELECT: begin
            if (sel_done) begin
               state_d = ST_RELEASE;
            end
         end
         ST_RELEASE: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= ST_IDLE;
         level_q <= `LEVEL_RESET;
         chan_q <= 2'h0;
         go_q <= 1'b0;
         clear_req_q <= 1'b0;
         clear_run_q <= 1'b0;
         done_q <= 1'b0;
         clr_done_q <= 1'b0;
         boot_q <= 1'b1;
         o_rdata <= 16'h0000;
         o_level_word <= 12'h000;
         o_channel_sel_low <= 1'b0;
         o_channel_sel_high <= 1'b0;
         o_load_n <= 1'b1;
         o_board_sel_n <= 1'b1;
         o_clear_n <= 1'b1;
      end else begin
         state_q <= state_d;
         if (clr_start) begin
            boot_q <= 1'b0;
            clear_req_q <= 1'b0;
            clear_run_q <= 1'b1;
         end else if (wr_ctrl && i_wdata[`CTRL_CLEAR_BIT]) begin
            clear_req_q <= 1'b1;
         end
         if (clr_done) begin
            clear_run_q <= 1'b0;
         end
         o_clear_n <= !(clr_start || (clr_active && !clr_done));
         if (wr_level && !busy) begin
            level_q <= i_wdata[11:0];
         end
         if (state_q == ST_SETUP) begin
            go_q <= 1'b0;
         end else if (wr_ctrl && i_wdata[`CTRL_GO_BIT] && !busy) begin
            go_q <= 1'b1;
            chan_q <= i_wdata[`CTRL_CH_MSB:`CTRL_CH_LSB];
         end
         if (state_q == ST_IDLE && state_d == ST_SETUP) begin
            o_level_word <= level_q;
            o_channel_sel_low <= chan_q[0];
            o_channel_sel_high <= chan_q[1];
            o_load_n <= 1'b0;
         end
         if (state_q == ST_SETUP) begin
            o_board_sel_n <= 1'b0;
         end
         if (state_q == ST_SELECT && sel_done) begin
            o_board_sel_n <= 1'b1;
         end
         if (state_q == ST_RELEASE) begin
            o_load_n <= 1'b1;
         end
         // Set wins over a read-clear in the same cycle.
         if (state_q == ST_RELEASE) begin
            done_q <= 1'b1;
         end else if (rd_status) begin
            done_q <= 1'b0;
         end
         if (clr_done) begin
            clr_done_q <= 1'b1;
         end else if (rd_status) begin
            clr_done_q <= 1'b0;
         end
         o_rdata <= 16'h0000;
         if (i_rd) begin
            case (i_addr)
               `REG_LEVEL: o_rdata <= {4'h0, level_q};
               `REG_CTRL: o_rdata <= {10'h000, chan_q, 2'h0, clear_req_q, go_q};
               `REG_STATUS: o_rdata <= {13'h0000, clr_done_q, done_q, busy};
               `REG_ID: o_rdata <= `ID_VALUE;
               default: begin
                  if ({i_addr[3:2], 2'h0} == `REG_SHADOW0) begin
                     o_rdata <= {4'h0, shadow_rd};
                  end else begin
                     o_rdata <= 16'h0000;
                  end
               end
            endcase
         end
      end
   end
   // The card's own power-up reset and its jumper are outside this controller's reach.
   // With the jumper fitted every write here is silently lost; busy still times out.
   // Each channel keeps a copy of what the card was last given, since the card cannot be read.
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_shadow
         reg [11:0] value_q;
         always @(posedge i_ref_clk or posedge i_rst) begin
            if (i_rst) begin
               value_q <= `LEVEL_RESET;
            end else if (clr_start) begin
               value_q <= `LEVEL_RESET;
            end else if (state_q == ST_SELECT && sel_done && chan_hot[g]) begin
               value_q <= o_level_word;
            end
         end
         assign shadow_w[g * 12 +: 12] = value_q;
      end
   endgenerate
   always @* begin
      case (i_addr[1:0])
         2'h0: shadow_rd = shadow_w[11:0];
         2'h1: shadow_rd = shadow_w[23:12];
         2'h2: shadow_rd = shadow_w[35:24];
         default: shadow_rd = shadow_w[47:36];
      endcase
   end
endmodule // dac_port_host

/* verification/dac_card_model.sv */
// Behavioural model of the four-channel driver card on the far side of the port.
`timescale 1ns/1ps
module dac_card_model #(
   parameter JUMPER_FITTED = 0
) (
   input wire [11:0] i_level_word,
   input wire i_channel_sel_low,
   input wire i_channel_sel_high,
   input wire i_load_n,
   input wire i_board_sel_n,
   input wire i_clear_n,
   output reg [47:0] o_levels
);
   initial o_levels = 48'h0;
   // The card has no clock, so capture is purely edge driven.
   always @(posedge i_board_sel_n or negedge i_clear_n) begin
      if (!i_clear_n) begin
         o_levels <= 48'h0;
      end else if (!i_load_n && JUMPER_FITTED == 0) begin
         o_levels[{i_channel_sel_high, i_channel_sel_low} * 12 +: 12] <= i_level_word;
      end
   end
endmodule // dac_card_model

/* verification/dac_port_host_assertions.sv */
// Checker of the card-side pin protocol of the DAC port controller.
`timescale 1ns/1ps
module dac_port_checker (
   input wire i_ref_clk,
   input wire i_rst,
   input wire [11:0] o_level_word,
   input wire o_channel_sel_low,
   input wire o_channel_sel_high,
   input wire o_load_n,
   input wire o_board_sel_n,
   input wire o_clear_n
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   sequence sel_pulse;
      !o_board_sel_n [*5] ##1 o_board_sel_n;
   endsequence
   sequence lines_held;
      ($stable(o_level_word) && $stable({o_channel_sel_high, o_channel_sel_low})) [*6];
   endsequence
   AST_SEL_WIDTH: assert property ($fell(o_board_sel_n) |-> sel_pulse)
      else $error("select low width wrong");
   AST_LINES_HELD: assert property ($fell(o_board_sel_n) |-> lines_held)
      else $error("data or channel moved while selected");
   AST_LOAD_FIRST: assert property ($fell(o_board_sel_n) |-> $past(!o_load_n))
      else $error("select asserted before load");
   AST_LOAD_AFTER: assert property ($rose(o_board_sel_n) |-> !o_load_n ##1 o_load_n)
      else $error("load line not released after select");
   AST_SEL_NEEDS_LOAD: assert property (o_load_n |-> o_board_sel_n)
      else $error("select low without load request");
   AST_CLR_WIDTH: assert property ($fell(o_clear_n) |-> !o_clear_n [*5] ##1 o_clear_n)
      else $error("clear pulse width wrong");
   AST_NO_OVERLAP: assert property (!(!o_board_sel_n && !o_clear_n))
      else $error("select during clear");
   AST_BOOT_CLEAR: assert property ($fell(i_rst) |-> ##[1:3] !o_clear_n)
      else $error("no clear pulse after reset");
endmodule // dac_port_checker
bind dac_port_host dac_port_checker dac_port_checker_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
   .o_level_word(o_level_word), .o_channel_sel_low(o_channel_sel_low),
   .o_channel_sel_high(o_channel_sel_high), .o_load_n(o_load_n),
   .o_board_sel_n(o_board_sel_n), .o_clear_n(o_clear_n));

/* verification/dac_port_host_tb.sv */
// Self-checking testbench of the DAC port controller against the card model.
`timescale 1ns/1ps
`include "dac_port_regs.vh"
module dac_port_host_tb;
   reg i_ref_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0;
   reg [3:0] i_addr = 4'h0;
   reg [15:0] i_wdata = 16'h0000, d;
   wire [15:0] o_rdata;
   wire [11:0] lw;
   wire sl, sh, ld, bs, cl;
   wire [47:0] lv, lvj;
   reg [11:0] e [0:3];
   integer seed = 5484, n_errors = 0, comparisons = 0, c, k;
   dac_port_host dac_port_host_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_level_word(lw),
      .o_channel_sel_low(sl), .o_channel_sel_high(sh), .o_load_n(ld), .o_board_sel_n(bs),
      .o_clear_n(cl));
   dac_card_model dac_card_model_i (.i_level_word(lw), .i_channel_sel_low(sl),
      .i_channel_sel_high(sh), .i_load_n(ld), .i_board_sel_n(bs), .i_clear_n(cl), .o_levels(lv));
   dac_card_model #(.JUMPER_FITTED(1)) jumpered_card_i (.i_level_word(lw),
      .i_channel_sel_low(sl), .i_channel_sel_high(sh), .i_load_n(ld), .i_board_sel_n(bs),
      .i_clear_n(cl), .o_levels(lvj));
   initial forever #5 i_ref_clk = ~i_ref_clk;
   function [47:0] pack(input integer u);
      pack = {e[3], e[2], e[1], e[0]};
   endfunction
   task chk(input [47:0] s, input [47:0] x);
      begin
         comparisons = comparisons + 1;
         if (s !== x) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED %0t seen %h expected %h", $time, s, x);
         end
      end
   endtask
   task wr(input [3:0] a, input [15:0] v);
      begin
         @(posedge i_ref_clk);
         i_wr <= 1;
         i_addr <= a;
         i_wdata <= v;
         @(posedge i_ref_clk);
         i_wr <= 0;
      end
   endtask
   task rd(input [3:0] a);
      begin
         @(posedge i_ref_clk);
         i_rd <= 1;
         i_addr <= a;
         @(posedge i_ref_clk);
         i_rd <= 0;
         #1 d = o_rdata;
      end
   endtask
   // Reading status clears its sticky bits, so one poll serves one event only.
   task wait_bit(input integer b);
      begin
         k = 0;
         d = 16'h0000;
         while (d[b] !== 1'b1 && k < 60) begin
            rd(`REG_STATUS);
            k = k + 1;
         end
         chk(d[b], 1'b1);
      end
   endtask
   task summarize;
      begin
         $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
         if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
         else $display("Testbench failed");
         $finish;
      end
   endtask
   initial begin
      #20000;
      n_errors = n_errors + 1;
      summarize;
   end
   initial begin
      repeat (2) @(posedge i_ref_clk);
      i_rst <= 0;
      for (c = 0; c < 4; c = c + 1) begin
         e[c] = 12'h000;
      end
      wait_bit(2);
      chk(lv, 48'h0);
      $display("Test boot clear done");
      for (c = 0; c < 4; c = c + 1) begin
         e[c] = $random(seed);
         wr(`REG_LEVEL, {4'h0, e[c]});
         wr(`REG_CTRL, {10'h000, c[1:0], 4'h1});
         wait_bit(1);
         chk(lv, pack(0));
      end
      for (c = 0; c < 4; c = c + 1) begin
         rd({2'h1, c[1:0]});
         chk(d, {4'h0, e[c]});
      end
      chk(lvj, 48'h0);
      $display("Test channel writes done");
      e[3] = 12'hFFF;
      wr(`REG_LEVEL, 16'h0FFF);
      wr(`REG_CTRL, 16'h0031);
      repeat (3) @(posedge i_ref_clk);
      wr(`REG_LEVEL, 16'h0000);
      wait_bit(1);
      chk(lv, pack(0));
      rd(`REG_LEVEL);
      chk(d, 16'h0FFF);
      $display("Test busy refusal done");
      wr(`REG_CTRL, 16'h0002);
      wait_bit(2);
      chk(lv, 48'h0);
      rd(4'h7);
      chk(d, 16'h0000);
      rd(`REG_ID);
      chk(d, `ID_VALUE);
      rd(4'hF);
      chk(d, 16'h0000);
      $display("Test clear and reads done");
      summarize;
   end
endmodule // dac_port_host_tb
